/* File: bench/pv_programmer.sv */
// Behavioural programmer that drives the program and verify pins
`timescale 1ns/1ps
module pv_programmer #(
  parameter int HALF_CYC = 5, // System cycles per device clock half period
  parameter int PULSE_LOW_CYC = 30, // Strobe low width, scaled down to keep the run short
  parameter int PULSE_GAP_CYC = 10 // Strobe high gap between pulses, scaled too
) (
  input wire logic clk_sys_i,
  output logic crystal_input_o,
  output logic reset_pin_o,
  output logic program_strobe_n_o,
  output logic vpp_logic_high_o,
  output logic vpp_program_level_o,
  output logic address_half_select_o,
  output logic [7:0] addr_port_o,
  output logic [7:0] drv_data_o, // Byte offered on the data port
  output logic drv_en_o // High while the programmer drives the data port
);
  int half_cnt = 0; // Position in the device clock half period
  // Pin levels at time zero
  initial begin
    crystal_input_o = 1'b0;
    reset_pin_o = 1'b1;
    program_strobe_n_o = 1'b1;
    vpp_logic_high_o = 1'b1;
    vpp_program_level_o = 1'b0;
    address_half_select_o = 1'b0;
    addr_port_o = 8'h00;
    drv_data_o = 8'h00;
    drv_en_o = 1'b0;
  end
  // Device clock runs free, it is the master clock of the part
  always @(posedge clk_sys_i) begin
    if (half_cnt == HALF_CYC - 1) begin
      half_cnt <= 0;
      crystal_input_o <= ~crystal_input_o;
    end else begin
      half_cnt <= half_cnt + 1;
    end
  end
  // Waits for falling device clock edges, so pin changes land while it is low
  task automatic dclk(input int n);
    repeat (n) begin
      do @(posedge clk_sys_i); while (!(half_cnt == HALF_CYC - 1 && crystal_input_o));
    end
  endtask : dclk
  // Arms with reset high, then shifts the mode code out
  task automatic send_code(input logic [9:0] code);
    reset_pin_o <= 1'b1;
    dclk(26);
    program_strobe_n_o <= 1'b1;
    vpp_logic_high_o <= 1'b1;
    dclk(1);
    for (int i = 0; i < 10; i++) begin
      reset_pin_o <= code[i];
      dclk(1);
    end
    reset_pin_o <= 1'b0;
    dclk(2);
  endtask : send_code
  // Like send_code, but strobe or supply drops from bit cut on, so no mode is entered
  task automatic send_code_cut(input logic [9:0] code, input int cut, input logic on_strobe);
    reset_pin_o <= 1'b1;
    dclk(26);
    program_strobe_n_o <= 1'b1;
    vpp_logic_high_o <= 1'b1;
    dclk(1);
    for (int i = 0; i < 10; i++) begin
      if (i == cut && on_strobe) begin
        program_strobe_n_o <= 1'b0;
      end else if (i == cut) begin
        vpp_logic_high_o <= 1'b0;
      end
      reset_pin_o <= code[i];
      dclk(1);
    end
    reset_pin_o <= 1'b0;
    program_strobe_n_o <= 1'b1;
    vpp_logic_high_o <= 1'b1;
    dclk(2);
  endtask : send_code_cut
  // Upper bits under select, then the low byte
  task automatic set_addr(input logic [10:0] a);
    address_half_select_o <= 1'b1;
    addr_port_o <= {5'h00, a[10:8]};
    dclk(14);
    address_half_select_o <= 1'b0;
    dclk(3);
    addr_port_o <= a[7:0];
    dclk(14);
  endtask : set_addr
  // High voltage, data, pulse train, then back to verify
  task automatic program_byte(input logic [7:0] d);
    dclk(24);
    vpp_program_level_o <= 1'b1;
    drv_data_o <= d;
    drv_en_o <= 1'b1;
    dclk(40);
    for (int i = 0; i < 25; i++) begin
      program_strobe_n_o <= 1'b0;
      repeat (PULSE_LOW_CYC) @(posedge clk_sys_i);
      program_strobe_n_o <= 1'b1;
      repeat (PULSE_GAP_CYC) @(posedge clk_sys_i);
    end
    dclk(48);
    drv_en_o <= 1'b0;
    vpp_program_level_o <= 1'b0;
    dclk(1);
  endtask : program_byte
endmodule : pv_programmer

/* File: bench/tb.sv */
// Self-checking bench for the program and verify port
`timescale 1ns/1ps
`include "pv_cfg.svh"
module tb;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic crystal, rst_pin, strobe_n, vpp_hi, vpp_hv, address_half_select, drv_en, oe, sec1, sec2, program_pulse_n_act;
  logic [7:0] addr, drv_data, data_in, data_out;
  logic [7:0] wire_last = 8'h00; // Last wire level, used for a floating port
  logic [4:0] pulses;
  pv_pkg::pv_mode_t mode;
  int err_count = 0;
  int checks_done = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  // Undriven port keeps flipping so a stale value never passes
  assign data_in = (oe === 1'b1) ? data_out : (drv_en ? drv_data : ~wire_last);
  always @(posedge clk_sys_i) wire_last <= data_in;
  // Programmer model on the far side of the pins
  pv_programmer program_pulse_n (
    .clk_sys_i(clk_sys_i),
    .crystal_input_o(crystal),
    .reset_pin_o(rst_pin),
    .program_strobe_n_o(strobe_n),
    .vpp_logic_high_o(vpp_hi),
    .vpp_program_level_o(vpp_hv),
    .address_half_select_o(address_half_select),
    .addr_port_o(addr),
    .drv_data_o(drv_data),
    .drv_en_o(drv_en)
  );
  // Port under test, full user array
  pv_program_pulse_n_port #(
    .USER_DEPTH(2048),
    .KEY_DEPTH(16)
  ) uut (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .crystal_input_i(crystal),
    .reset_pin_i(rst_pin),
    .program_strobe_n_i(strobe_n),
    .vpp_logic_high_i(vpp_hi),
    .vpp_program_level_i(vpp_hv),
    .address_half_select_i(address_half_select),
    .addr_port_i(addr),
    .data_port_i(data_in),
    .data_port_o(data_out),
    .data_port_oe_o(oe),
    .mode_o(mode),
    .program_active_o(program_pulse_n_act),
    .pulse_count_o(pulses),
    .sec1_programmed_o(sec1),
    .sec2_programmed_o(sec2)
  );
  // One comparison, counted
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Verify read after a wait in device clocks
  task automatic rd(input logic [7:0] exp, input int n);
    program_pulse_n.dclk(n);
    chk({7'h00, oe}, 8'h01);
    chk(data_out, exp);
  endtask : rd
  // Mode check
  task automatic chk_mode(input pv_pkg::pv_mode_t m);
    chk({5'h00, mode}, {5'h00, m});
  endtask : chk_mode
  // Verdict and end of run
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    chk({7'h00, oe}, 8'h00);
    chk({6'h00, sec1, sec2}, 8'h00);
    // Unknown code enters nothing
    program_pulse_n.send_code(10'h294);
    chk_mode(pv_pkg::PV_MODE_NONE);
    chk({7'h00, oe}, 8'h00);
    // Supply, then strobe, dropped during the shift abandons the code
    program_pulse_n.send_code_cut(`PV_CODE_USER, 4, 1'b0);
    chk_mode(pv_pkg::PV_MODE_NONE);
    program_pulse_n.send_code_cut(`PV_CODE_USER, 7, 1'b1);
    chk_mode(pv_pkg::PV_MODE_NONE);
    // Pure verify of an erased byte
    program_pulse_n.send_code(`PV_CODE_USER);
    chk_mode(pv_pkg::PV_MODE_USER);
    program_pulse_n.set_addr(11'h123);
    rd(8'hff, 1);
    // Program a user byte, port turns input under high voltage
    fork
      program_pulse_n.program_byte(8'h5a);
      begin
        program_pulse_n.dclk(30);
        chk({6'h00, oe, program_pulse_n_act}, 8'h01);
        program_pulse_n.dclk(150);
        chk({3'h0, pulses}, 8'h19);
      end
    join
    rd(8'h5a, 48);
    // Key byte 3, then user verify is encrypted by it
    program_pulse_n.send_code(`PV_CODE_KEY);
    program_pulse_n.set_addr(11'h003);
    program_pulse_n.program_byte(8'h0f);
    rd(8'h0f, 48);
    program_pulse_n.send_code(`PV_CODE_USER);
    program_pulse_n.set_addr(11'h123);
    rd(8'haa, 48);
    program_pulse_n.set_addr(11'h124);
    rd(8'hff, 13);
    program_pulse_n.set_addr(11'h133);
    rd(8'h0f, 13);
    // Security bit 1 with no address or data
    program_pulse_n.send_code(`PV_CODE_SEC1);
    program_pulse_n.program_byte(8'h00);
    chk({6'h00, sec1, sec2}, 8'h02);
    rd(8'h80, 48);
    // Key verify and key or user programming now blocked
    program_pulse_n.send_code(`PV_CODE_KEY);
    program_pulse_n.set_addr(11'h003);
    rd(8'hff, 48);
    program_pulse_n.program_byte(8'h00);
    program_pulse_n.send_code(`PV_CODE_USER);
    program_pulse_n.set_addr(11'h123);
    program_pulse_n.program_byte(8'h00);
    rd(8'haa, 48);
    // Security bit 2 hides the arrays but not the bits
    program_pulse_n.send_code(`PV_CODE_SEC2);
    program_pulse_n.program_byte(8'h00);
    chk({6'h00, sec1, sec2}, 8'h03);
    program_pulse_n.send_code(`PV_CODE_SEC1);
    rd(8'hc0, 48);
    program_pulse_n.send_code(`PV_CODE_USER);
    program_pulse_n.set_addr(11'h123);
    rd(8'hff, 48);
    end_of_test();
  end
  // Watchdog, about three times the expected run
  initial begin
    #700000;
    err_count++;
    $display("MISMATCH at %0t: run did not finish", $time);
    end_of_test();
  end
endmodule : tb

/* File: logic/pv_cfg.svh */
// Constants of the program and verify port
`ifndef PV_CFG_SVH
`define PV_CFG_SVH
`define PV_CODE_W 10
`define PV_CODE_USER 10'h296
`define PV_CODE_KEY 10'h292
`define PV_CODE_SEC1 10'h29a
`define PV_CODE_SEC2 10'h298
`define PV_CLK_PER_MCYC 12
`define PV_ARM_MCYC 2
`define PV_ARM_CLKS (`PV_ARM_MCYC * `PV_CLK_PER_MCYC)
`define PV_PULSES 25
`define PV_ERASED_BYTE 8'hff
`define PV_SEC1_BIT 7
`define PV_SEC2_BIT 6
`define PV_KEY_DEPTH 16
`define PV_USER_DEPTH 2048
`define PV_ADDR_HI_W 3
`endif

/* File: logic/pv_code_if.sv */
// Link between the port core and the serial code receiver
`timescale 1ns/1ps
interface pv_code_if;
  logic osc_rise; // Device clock rising edge, synced
  logic rst_pin; // Reset pin level, synced
  logic pins_hi; // Strobe and supply pins both at logic high
  pv_pkg::pv_mode_t mode; // Selected operation
  modport rx (input osc_rise, input rst_pin, input pins_hi, output mode);
  modport core (output osc_rise, output rst_pin, output pins_hi, input mode);
endinterface : pv_code_if

/* File: logic/pv_code_rx.sv */
// Serial mode-code receiver on the reset pin
`timescale 1ns/1ps
`include "pv_cfg.svh"
module pv_code_rx (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  pv_code_if.rx cif
);
  // Whole receiver state
  typedef struct packed {
    pv_pkg::pv_rx_state_t st;
    logic [4:0] arm_cnt;
    logic [3:0] bit_cnt;
    logic [`PV_CODE_W-1:0] shreg;
    pv_pkg::pv_mode_t mode;
  } pv_rx_st_t;
  localparam pv_rx_st_t RX_RST = '{st: pv_pkg::PV_RX_WAIT_HIGH, arm_cnt: 5'h00,
    bit_cnt: 4'h0, shreg: 10'h000, mode: pv_pkg::PV_MODE_NONE};
  pv_rx_st_t q_reg;
  pv_rx_st_t q_next;
  logic [`PV_CODE_W-1:0] full_code; // Code including the bit now sampled
  logic last_bit; // Tenth bit being sampled

  assign full_code = {cif.rst_pin, q_reg.shreg[`PV_CODE_W-1:1]};
  assign last_bit = (q_reg.bit_cnt == 4'(`PV_CODE_W - 1));
  assign cif.mode = q_reg.mode;

  // Next state
  always_comb begin
    q_next = q_reg;
    case (q_reg.st)
      pv_pkg::PV_RX_WAIT_HIGH: begin
        q_next.mode = pv_pkg::PV_MODE_NONE;
        if (cif.osc_rise) begin
          if (!cif.rst_pin) begin
            q_next.arm_cnt = 5'h00;
          end else if (q_reg.arm_cnt == 5'(`PV_ARM_CLKS - 1)) begin
            q_next.st = pv_pkg::PV_RX_ARMED;
          end else begin
            q_next.arm_cnt = q_reg.arm_cnt + 5'h01;
          end
        end
      end
      pv_pkg::PV_RX_ARMED: begin
        // All codes start with a zero, so the first low sample opens the code
        if (cif.osc_rise && !cif.rst_pin) begin
          q_next.arm_cnt = 5'h00;
          if (cif.pins_hi) begin
            q_next.st = pv_pkg::PV_RX_SHIFT;
            q_next.bit_cnt = 4'h1;
            q_next.shreg = full_code;
          end else begin
            q_next.st = pv_pkg::PV_RX_WAIT_HIGH;
          end
        end
      end
      pv_pkg::PV_RX_SHIFT: begin
        if (!cif.pins_hi) begin
          q_next.st = pv_pkg::PV_RX_WAIT_HIGH;
        end else if (cif.osc_rise) begin
          // Sampled on the clock high phase, least significant bit first
          q_next.shreg = full_code;
          q_next.bit_cnt = q_reg.bit_cnt + 4'h1;
          if (last_bit) begin
            q_next.arm_cnt = 5'h00; // No low sample seen yet after the code
            case (full_code)
              `PV_CODE_USER: q_next.mode = pv_pkg::PV_MODE_USER;
              `PV_CODE_KEY: q_next.mode = pv_pkg::PV_MODE_KEY;
              `PV_CODE_SEC1: q_next.mode = pv_pkg::PV_MODE_SEC1;
              `PV_CODE_SEC2: q_next.mode = pv_pkg::PV_MODE_SEC2;
              default: q_next.mode = pv_pkg::PV_MODE_NONE;
            endcase
            q_next.st = (q_next.mode == pv_pkg::PV_MODE_NONE) ?
              pv_pkg::PV_RX_WAIT_HIGH : pv_pkg::PV_RX_DONE;
          end
        end
      end
      pv_pkg::PV_RX_DONE: begin
        // The tenth bit of every code is a one, so only a rise after a low ends it
        if (!cif.rst_pin) begin
          q_next.arm_cnt = 5'h01; // Low seen since the code
        end else if (q_reg.arm_cnt[0]) begin
          q_next.st = pv_pkg::PV_RX_WAIT_HIGH;
          q_next.mode = pv_pkg::PV_MODE_NONE;
          q_next.arm_cnt = 5'h00;
        end
      end
      default: begin
        q_next = RX_RST;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      q_reg <= RX_RST;
    end else begin
      q_reg <= q_next;
    end
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  rx_arm_gate_a: assert property (
    q_reg.st == pv_pkg::PV_RX_WAIT_HIGH ##1 q_reg.st == pv_pkg::PV_RX_ARMED
    |-> $past(q_reg.arm_cnt) == 5'(`PV_ARM_CLKS - 1))
    else $error("code receiver armed too early");
  rx_pins_drop_a: assert property (
    q_reg.st == pv_pkg::PV_RX_SHIFT && !cif.pins_hi |=> q_reg.st == pv_pkg::PV_RX_WAIT_HIGH)
    else $error("shift continued with strobe or supply low");
  rx_bit_sample_a: assert property (
    q_reg.st == pv_pkg::PV_RX_SHIFT && cif.pins_hi && cif.osc_rise
    |=> q_reg.shreg[`PV_CODE_W-1] == $past(cif.rst_pin))
    else $error("serial bit not taken at clock rise");
  rx_exit_a: assert property (
    q_reg.st == pv_pkg::PV_RX_DONE && q_reg.arm_cnt[0] && cif.rst_pin
    |=> cif.mode == pv_pkg::PV_MODE_NONE)
    else $error("mode held with reset pin high");
  rx_bad_code_a: assert property (
    q_reg.st == pv_pkg::PV_RX_SHIFT && q_next.st == pv_pkg::PV_RX_WAIT_HIGH
    |=> cif.mode == pv_pkg::PV_MODE_NONE [*2])
    else $error("mode entered on unknown code");
endmodule : pv_code_rx

/* File: logic/pv_pkg.sv */
// Types of the program and verify port
package pv_pkg;
  // Operation selected by the serial code
  typedef enum logic [2:0] {
    PV_MODE_NONE,
    PV_MODE_USER,
    PV_MODE_KEY,
    PV_MODE_SEC1,
    PV_MODE_SEC2
  } pv_mode_t;
  // Serial code receiver states
  typedef enum logic [1:0] {
    PV_RX_WAIT_HIGH,
    PV_RX_ARMED,
    PV_RX_SHIFT,
    PV_RX_DONE
  } pv_rx_state_t;
endpackage : pv_pkg

/* File: logic/pv_program_pulse_n_port.sv */
// Program and verify port of the on-chip code memory
`timescale 1ns/1ps
`include "pv_cfg.svh"
module pv_program_pulse_n_port #(
  parameter int USER_DEPTH = `PV_USER_DEPTH, // Bytes of the user array
  parameter int KEY_DEPTH = `PV_KEY_DEPTH // Bytes of the key table
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic crystal_input_i, // Device clock from the programmer
  input wire logic reset_pin_i, // Serial code input
  input wire logic program_strobe_n_i, // Programming pulses, active low
  input wire logic vpp_logic_high_i, // Supply pin at logic high
  input wire logic vpp_program_level_i, // Supply pin at programming voltage
  input wire logic address_half_select_i, // High while upper address shown
  input wire logic [7:0] addr_port_i, // Multiplexed address
  input wire logic [7:0] data_port_i, // Data port, input half
  output logic [7:0] data_port_o, // Data port, output half
  output logic data_port_oe_o, // Data port driven by the device
  output pv_pkg::pv_mode_t mode_o, // Operation in force
  output logic program_active_o, // Programming voltage applied in a mode
  output logic [4:0] pulse_count_o, // Strobe pulses seen this byte
  output logic sec1_programmed_o, // Program inhibit bit set
  output logic sec2_programmed_o // Verify inhibit bit set
);
  // Positions within the synchronised pin vector
  localparam int P_OSC = 0;
  localparam int P_RST = 1;
  localparam int P_STB = 2;
  localparam int P_VIH = 3;
  localparam int P_VPP = 4;
  localparam int P_ADDRESS_HALF_SELECT = 5;
  localparam int PIN_N = 6;
  localparam int AW = `PV_ADDR_HI_W + 8;
  localparam int KW = $clog2(KEY_DEPTH);

  // Whole port state; the arrays model the nonvolatile cells
  typedef struct packed {
    logic [PIN_N-1:0] pin_s1; // First synchroniser stage
    logic [PIN_N-1:0] pin_s2; // Second synchroniser stage
    logic [7:0] addr_s1;
    logic [7:0] addr_s2;
    logic [7:0] dat_s1;
    logic [7:0] dat_s2;
    logic osc_prev; // Device clock, one sample back
    logic strobe_prev; // Strobe, one sample back
    logic [`PV_ADDR_HI_W-1:0] addr_hi; // Latched upper address
    logic [4:0] pulse_cnt;
    logic [USER_DEPTH-1:0][7:0] umem;
    logic [KEY_DEPTH-1:0][7:0] kmem;
    logic [1:0] sec_cell; // Cell level, one when erased
    logic [7:0] dout;
    logic oe;
  } pv_core_st_t;

  // Reset starts from erased cells; strobe stages idle high, so no false rise
  localparam pv_core_st_t CORE_RST = '{pin_s1: 6'h04, pin_s2: 6'h04, addr_s1: 8'h00,
    addr_s2: 8'h00, dat_s1: 8'h00, dat_s2: 8'h00, osc_prev: 1'b0, strobe_prev: 1'b1,
    addr_hi: 3'h0, pulse_cnt: 5'h00, umem: '1, kmem: '1, sec_cell: 2'h3,
    dout: 8'h00, oe: 1'b0};

  pv_core_st_t q_reg;
  pv_core_st_t q_next;
  pv_code_if cif ();
  logic hv; // Programming voltage, synced
  logic strobe_rise; // End of one programming pulse
  logic [AW-1:0] addr; // Full address in force
  logic [KW-1:0] kidx; // Key slot for this address
  logic sec1; // Program inhibit in force
  logic sec2; // Verify inhibit in force

  assign hv = q_reg.pin_s2[P_VPP];
  assign strobe_rise = q_reg.pin_s2[P_STB] && !q_reg.strobe_prev;
  assign addr = {q_reg.addr_hi, q_reg.addr_s2};
  assign kidx = addr[KW-1:0];
  assign sec1 = !q_reg.sec_cell[0];
  assign sec2 = !q_reg.sec_cell[1];

  // Inputs to the code receiver
  assign cif.osc_rise = q_reg.pin_s2[P_OSC] && !q_reg.osc_prev;
  assign cif.rst_pin = q_reg.pin_s2[P_RST];
  assign cif.pins_hi = q_reg.pin_s2[P_STB] && q_reg.pin_s2[P_VIH];

  pv_code_rx u_rx (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .cif(cif.rx)
  );

  // Next state: sync, address latch, programming and verify data
  always_comb begin
    logic [7:0] rd;
    logic [7:0] ubyte;
    rd = `PV_ERASED_BYTE;
    ubyte = `PV_ERASED_BYTE;
    q_next = q_reg;
    // Pins come from the programmer's domain
    q_next.pin_s1 = {address_half_select_i, vpp_program_level_i, vpp_logic_high_i,
      program_strobe_n_i, reset_pin_i, crystal_input_i};
    q_next.pin_s2 = q_reg.pin_s1;
    q_next.addr_s1 = addr_port_i;
    q_next.addr_s2 = q_reg.addr_s1;
    q_next.dat_s1 = data_port_i;
    q_next.dat_s2 = q_reg.dat_s1;
    q_next.osc_prev = q_reg.pin_s2[P_OSC];
    q_next.strobe_prev = q_reg.pin_s2[P_STB];
    // Upper bits follow the port while select is high, frozen once low
    if (q_reg.pin_s2[P_ADDRESS_HALF_SELECT]) begin
      q_next.addr_hi = q_reg.addr_s2[`PV_ADDR_HI_W-1:0];
    end
    // Compared at full width: the depth needs one bit more than the address
    if (int'(addr) < USER_DEPTH) begin
      ubyte = q_reg.umem[addr];
    end
    // Programming: each pulse ANDs the byte in, so repeats are harmless
    if (!hv || cif.mode == pv_pkg::PV_MODE_NONE) begin
      q_next.pulse_cnt = 5'h00;
    end else if (strobe_rise) begin
      if (q_reg.pulse_cnt != 5'h1f) begin
        q_next.pulse_cnt = q_reg.pulse_cnt + 5'h01;
      end
      case (cif.mode)
        pv_pkg::PV_MODE_USER: begin
          if (!sec1 && int'(addr) < USER_DEPTH) begin
            q_next.umem[addr] = ubyte & q_reg.dat_s2;
          end
        end
        pv_pkg::PV_MODE_KEY: begin
          if (!sec1) begin
            q_next.kmem[kidx] = q_reg.kmem[kidx] & q_reg.dat_s2;
          end
        end
        // Security bits ignore address and data
        pv_pkg::PV_MODE_SEC1: q_next.sec_cell[0] = 1'b0;
        pv_pkg::PV_MODE_SEC2: q_next.sec_cell[1] = 1'b0;
        default: q_next.pulse_cnt = q_reg.pulse_cnt;
      endcase
    end
    // Verify data; blocked reads return the erased pattern
    case (cif.mode)
      pv_pkg::PV_MODE_USER: begin
        if (!sec2) begin
          rd = ubyte ~^ q_reg.kmem[kidx];
        end
      end
      pv_pkg::PV_MODE_KEY: begin
        if (!sec1 && !sec2) begin
          rd = q_reg.kmem[kidx];
        end
      end
      pv_pkg::PV_MODE_SEC1: begin
        rd = 8'h00;
        rd[`PV_SEC1_BIT] = sec1;
        rd[`PV_SEC2_BIT] = sec2;
      end
      default: rd = `PV_ERASED_BYTE;
    endcase
    // Data updates within a few system cycles, far inside 14 device clocks
    q_next.dout = rd;
    // Driven in any mode but PV_MODE_NONE, unless the programming voltage is on
    q_next.oe = (cif.mode != pv_pkg::PV_MODE_NONE) && !hv;
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      q_reg <= CORE_RST;
    end else begin
      q_reg <= q_next;
    end
  end

  // Outputs
  assign data_port_o = q_reg.dout;
  assign data_port_oe_o = q_reg.oe;
  assign mode_o = cif.mode;
  assign program_active_o = hv && (cif.mode != pv_pkg::PV_MODE_NONE);
  assign pulse_count_o = q_reg.pulse_cnt;
  assign sec1_programmed_o = sec1;
  assign sec2_programmed_o = sec2;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  oe_addr_load_a: assert property (
    cif.mode != pv_pkg::PV_MODE_NONE && !hv |=> data_port_oe_o)
    else $error("data port not driven during address load");
  oe_high_volt_a: assert property (
    hv |=> !data_port_oe_o)
    else $error("data port driven under programming voltage");
  verify_resume_a: assert property (
    $fell(hv) && cif.mode != pv_pkg::PV_MODE_NONE ##1 cif.mode != pv_pkg::PV_MODE_NONE
    |-> data_port_oe_o)
    else $error("verify output not resumed after voltage drop");
  key_xnor_a: assert property (
    cif.mode == pv_pkg::PV_MODE_USER && !sec2 && $stable(addr) && int'(addr) < USER_DEPTH
    |=> data_port_o == ~($past(q_reg.umem[addr]) ^ $past(q_reg.kmem[kidx])))
    else $error("user verify not encrypted with key slot");
  low_addr_data_a: assert property (
    cif.mode == pv_pkg::PV_MODE_SEC1 && !hv ##1 cif.mode == pv_pkg::PV_MODE_SEC1 [*3]
    |-> data_port_o[`PV_SEC1_BIT] == sec1_programmed_o)
    else $error("verify data late");
  sec1_lock_a: assert property (
    sec1 && cif.mode == pv_pkg::PV_MODE_KEY |=> data_port_o == `PV_ERASED_BYTE
    && $stable(q_reg.kmem))
    else $error("key reached with program inhibit set");
  sec2_lock_a: assert property (
    sec2 && cif.mode == pv_pkg::PV_MODE_USER ##1 cif.mode == pv_pkg::PV_MODE_USER
    |-> data_port_o == `PV_ERASED_BYTE)
    else $error("user array read with verify inhibit set");
  sec_readback_a: assert property (
    cif.mode == pv_pkg::PV_MODE_SEC1 ##1 cif.mode == pv_pkg::PV_MODE_SEC1
    |-> data_port_o[`PV_SEC2_BIT] == !$past(q_reg.sec_cell[1]) && data_port_o[5:0] == 6'h00)
    else $error("security readback wrong");
  sec2_program_pulse_n_a: assert property (
    cif.mode == pv_pkg::PV_MODE_SEC2 && hv && strobe_rise |=> sec2_programmed_o)
    else $error("security bit 2 not programmed");

  program_pulse_n_user_c: cover property (
    cif.mode == pv_pkg::PV_MODE_USER && hv && strobe_rise && pulse_count_o == 5'h18);
  verify_user_c: cover property (
    cif.mode == pv_pkg::PV_MODE_USER && !hv && data_port_oe_o);
  key_verify_c: cover property (cif.mode == pv_pkg::PV_MODE_KEY && data_port_oe_o);
  sec_verify_c: cover property (cif.mode == pv_pkg::PV_MODE_SEC1 && sec1 && sec2);
endmodule : pv_program_pulse_n_port
